// ---- core/fssm_alu.sv ----
// Purpose: float ALU slice for reciprocal seed, reciprocal square-root seed,
//          sign copy and minimum, with arithmetic and sticky status.
// Assumes: one core clock, synchronous active-low reset, operands valid with i_op_valid.
// Notes:   result and both status words register one clock after the request.
//
// Function
// - reciprocal seed mantissa from 7-bit ROM index
// - reciprocal exponent is minus e minus one
// - reciprocal of zero gives signed infinity, overflow
// - reciprocal exponent above 125 gives zero
// - reciprocal of NaN gives ones, invalid
// - reciprocal negative follows operand sign unless NaN; carry, select cleared
// - reciprocal sets sticky underflow, invalid, overflow
// - root seed mantissa from exponent lsb, six bits
// - root exponent is negated e halved minus one
// - root of zero infinity; plus infinity gives zero
// - root of NaN or negative gives ones
// - root negative only for minus zero
// - root sets sticky invalid and overflow only
// - copysign keeps x magnitude, takes y sign
// - copysign flushes denormals; NaN gives all ones
// - copysign/min flags: invalid, negative, zero; others cleared
// - min returns smaller; minus zero beats plus zero
// - min flushes denormals; NaN gives all ones
// - copysign/min set only sticky invalid

`timescale 1ns/1ns
`default_nettype none

module fssm_alu
   import fssm_pkg::*;
(
   // clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RSTN,
   // request from the instruction decoder
   input wire logic I_OP_VALID,
   input wire fssm_op_t I_OP_CODE,
   input wire logic [FSSM_W-1:0] I_OPND_X,
   input wire logic [FSSM_W-1:0] I_OPND_Y,
   // sticky word clear from the core
   input wire logic I_STICKY_CLR,
   // write-back to the register file
   output logic O_RES_VALID,
   output logic [FSSM_W-1:0] O_RESULT,
   output fssm_arith_status_word_t O_ARITH_STATUS,
   output fssm_sticky_status_word_t O_STICKY_STATUS
);

   typedef struct packed {
      logic res_valid;
      logic [31:0] result;
      fssm_arith_status_word_t arith;
      fssm_sticky_status_word_t sticky;
   } fssm_state_t;

   fssm_state_t st_r;
   fssm_state_t st_nxt;
   logic [FSSM_RCP_FRAC_W-1:0] rcp_frac;
   logic [FSSM_RSQ_FRAC_W-1:0] rsq_frac;
   fssm_out_t op_out;

   ////////////////////////////////////////////////////////////////////////////////
   // operand classification

   function automatic logic [7:0] exp_of(input logic [31:0] v);
      return v[FSSM_EXP_HI:FSSM_EXP_LO];
   endfunction

   function automatic logic is_nan(input logic [31:0] v);
      return (exp_of(v) == FSSM_EXP_ALL1) && (v[FSSM_FRAC_W-1:0] != '0);
   endfunction

   function automatic logic is_inf(input logic [31:0] v);
      return (exp_of(v) == FSSM_EXP_ALL1) && (v[FSSM_FRAC_W-1:0] == '0);
   endfunction

   // denormals count as zero everywhere in this slice
   function automatic logic is_zero(input logic [31:0] v);
      return exp_of(v) == FSSM_EXP_ZERO;
   endfunction

   // the sign is kept so that a flushed minus zero still wins the minimum
   function automatic logic [31:0] flush(input logic [31:0] v);
      return is_zero(v) ? {v[FSSM_SIGN_POS], 31'h00000000} : v;
   endfunction

   // true when a is strictly below b; both already flushed, neither NaN
   function automatic logic less_than(input logic [31:0] a, input logic [31:0] b);
      logic lt;
      lt = 1'b0;
      if (a[FSSM_SIGN_POS] != b[FSSM_SIGN_POS]) begin
         // differing signs: the negative one is smaller, which orders -0 below +0
         lt = a[FSSM_SIGN_POS];
      end else if (a[FSSM_SIGN_POS] == 1'b0) begin
         // exponent above fraction: magnitudes order as plain integers
         lt = a[30:0] < b[30:0];
      end else begin
         lt = a[30:0] > b[30:0];
      end
      return lt;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // reciprocal seed

   function automatic fssm_out_t do_recip(input logic [31:0] x,
                                          input logic [FSSM_RCP_FRAC_W-1:0] frac);
      fssm_out_t o;
      logic s;
      logic nan;
      o = '0;
      s = x[FSSM_SIGN_POS];
      nan = is_nan(x);
      if (nan) begin
         o.result = FSSM_ALL_ONES;
         o.flags.alu_invalid_flag = 1'b1;
      end else if (is_zero(x)) begin
         o.result = {s, FSSM_EXP_ALL1, 23'h000000};
         o.flags.alu_overflow_flag = 1'b1;
      end else if (exp_of(x) > FSSM_RCP_EXP_MAX) begin
         o.result = {s, 31'h00000000};
         o.flags.alu_zero_flag = 1'b1;
      end else begin
         // E is 1..252 here, so 253 - E stays a normal exponent
         // negated exponent minus one
         o.result[FSSM_EXP_HI:FSSM_EXP_LO] = FSSM_RCP_EXP_SUM - exp_of(x);
         o.result[FSSM_SIGN_POS] = s;
         o.result[22:15] = frac;
      end
      // sign flag, carry and select clear
      o.flags.alu_negative_flag = s & ~nan;
      o.flags.alu_carry_flag = 1'b0;
      o.flags.alu_sign_select_flag = 1'b0;
      o.set.sticky_underflow_bit = o.flags.alu_zero_flag;
      o.set.sticky_invalid_bit = o.flags.alu_invalid_flag;
      o.set.sticky_overflow_bit = o.flags.alu_overflow_flag;
      // fixed-point overflow is never raised here; only the clear input or reset drops it
      o.set.sticky_fixed_overflow_bit = 1'b0;
      return o;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // reciprocal square-root seed

   function automatic fssm_out_t do_rsqrt(input logic [31:0] x,
                                          input logic [FSSM_RSQ_FRAC_W-1:0] frac);
      fssm_out_t o;
      logic s;
      logic signed [9:0] unb;
      logic signed [9:0] neg;
      logic signed [9:0] rexp;
      o = '0;
      s = x[FSSM_SIGN_POS];
      unb = $signed({2'b00, exp_of(x)}) - $signed(FSSM_BIAS);
      neg = -unb;
      // the arithmetic shift floors odd values toward minus infinity
      // halve negated exponent, minus one
      rexp = (neg >>> 1) - 10'sd1 + $signed(FSSM_BIAS);
      if (is_nan(x) || (s && !is_zero(x))) begin
         o.result = FSSM_ALL_ONES;
         o.flags.alu_invalid_flag = 1'b1;
      end else if (is_zero(x)) begin
         o.result = {s, FSSM_EXP_ALL1, 23'h000000};
         o.flags.alu_overflow_flag = 1'b1;
         o.flags.alu_negative_flag = s;
      end else if (is_inf(x)) begin
         o.result = FSSM_RESULT_RST;
         o.flags.alu_zero_flag = 1'b1;
      end else begin
         o.result[FSSM_SIGN_POS] = s;
         o.result[FSSM_EXP_HI:FSSM_EXP_LO] = rexp[7:0];
         o.result[22:19] = frac;
      end
      o.set.sticky_invalid_bit = o.flags.alu_invalid_flag;
      o.set.sticky_overflow_bit = o.flags.alu_overflow_flag;
      // underflow and fixed overflow stay as they were
      o.set.sticky_underflow_bit = 1'b0;
      o.set.sticky_fixed_overflow_bit = 1'b0;
      o.flags.alu_carry_flag = 1'b0;
      o.flags.alu_sign_select_flag = 1'b0;
      return o;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // sign copy and minimum share their flag behaviour

   function automatic fssm_out_t two_opnd_flags(input logic [31:0] r, input logic nan);
      fssm_out_t o;
      o = '0;
      // a NaN answer reports no sign: the all-ones word is not a number
      // invalid negative zero
      if (nan) begin
         o.result = FSSM_ALL_ONES;
         o.flags.alu_invalid_flag = 1'b1;
      end else begin
         o.result = r;
         o.flags.alu_negative_flag = r[FSSM_SIGN_POS];
         o.flags.alu_zero_flag = is_zero(r);
      end
      o.flags.alu_carry_flag = 1'b0;
      o.flags.alu_sign_select_flag = 1'b0;
      o.flags.alu_overflow_flag = 1'b0;
      o.set.sticky_invalid_bit = o.flags.alu_invalid_flag;
      o.set.sticky_underflow_bit = 1'b0;
      o.set.sticky_fixed_overflow_bit = 1'b0;
      o.set.sticky_overflow_bit = 1'b0;
      return o;
   endfunction

   function automatic fssm_out_t do_copysign(input logic [31:0] x, input logic [31:0] y);
      logic [31:0] fx;
      fx = flush(x);
      // flush and NaN
      // the sign of y is taken raw, even from a denormal y
      // x magnitude, y sign
      return two_opnd_flags({y[FSSM_SIGN_POS], fx[30:0]}, is_nan(x) | is_nan(y));
   endfunction

   function automatic fssm_out_t do_min(input logic [31:0] x, input logic [31:0] y);
      logic [31:0] fx;
      logic [31:0] fy;
      fx = flush(x);
      fy = flush(y);
      return two_opnd_flags(less_than(fy, fx) ? fy : fx, is_nan(x) | is_nan(y));
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // seed tables

   // both seeds read x only; y is ignored by the seed operations
   // seven index bits each: x fraction, or exponent lsb and six fraction bits
   fssm_seed_rom u_rom (
      .i_rcp_idx(I_OPND_X[22:16]),
      .i_rsq_idx({I_OPND_X[FSSM_EXP_LO], I_OPND_X[22:17]}),
      .o_rcp_frac(rcp_frac),
      .o_rsq_frac(rsq_frac)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // operation select and state update

   always_comb begin
      unique case (I_OP_CODE)
         FSSM_OP_RECIP: op_out = do_recip(I_OPND_X, rcp_frac);
         FSSM_OP_RSQRT: op_out = do_rsqrt(I_OPND_X, rsq_frac);
         FSSM_OP_COPYSIGN: op_out = do_copysign(I_OPND_X, I_OPND_Y);
         FSSM_OP_MIN: op_out = do_min(I_OPND_X, I_OPND_Y);
      endcase
   end

   // single-cycle answer; reset wins, so a request seen during reset is dropped
   always_comb begin
      st_nxt = st_r;
      // the strobe lasts one cycle unless requests follow back to back
      st_nxt.res_valid = I_OP_VALID;
      // a clear and a same-cycle set: the set wins so no event is lost
      if (I_STICKY_CLR) begin
         st_nxt.sticky = FSSM_STICKY_RST;
      end
      if (I_OP_VALID) begin
         st_nxt.result = op_out.result;
         st_nxt.arith = op_out.flags;
         st_nxt.sticky = st_nxt.sticky | op_out.set;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RSTN) begin
         st_r <= '{res_valid: 1'b0, result: FSSM_RESULT_RST,
                   arith: FSSM_ARITH_RST, sticky: FSSM_STICKY_RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign O_RES_VALID = st_r.res_valid;
   assign O_RESULT = st_r.result;
   assign O_ARITH_STATUS = st_r.arith;
   assign O_STICKY_STATUS = st_r.sticky;

endmodule

`default_nettype wire

// ---- core/fssm_pkg.sv ----
// Purpose: shared types and constants of the seed/sign/min float ALU slice,
//          plus the seed lookup ROM that the slice instantiates.
// Assumes: single-precision layout, sign bit 31, 8-bit exponent, 23-bit fraction.
// Notes:   the ROM contents are built from constant functions at elaboration.

package fssm_pkg;

   // operand layout
   localparam int FSSM_W = 32;
   localparam int FSSM_SIGN_POS = 31;
   localparam int FSSM_EXP_HI = 30;
   localparam int FSSM_EXP_LO = 23;
   localparam int FSSM_FRAC_W = 23;
   localparam logic [7:0] FSSM_EXP_ALL1 = 8'hFF;
   localparam logic [7:0] FSSM_EXP_ZERO = 8'h00;
   localparam logic [31:0] FSSM_ALL_ONES = 32'hFFFFFFFF;
   localparam logic [9:0] FSSM_BIAS = 10'h07F;

   // reciprocal seed: 7-bit index, 8 stored fraction bits
   localparam int FSSM_RCP_IDX_W = 7;
   localparam int FSSM_RCP_FRAC_W = 8;
   // biased exponent above 127 + 125 gives a zero seed
   localparam logic [7:0] FSSM_RCP_EXP_MAX = 8'hFC;
   // biased result exponent = 253 - biased operand exponent
   localparam logic [7:0] FSSM_RCP_EXP_SUM = 8'hFD;

   // reciprocal square-root seed: exponent lsb plus six fraction bits, 4-bit seed
   localparam int FSSM_RSQ_IDX_W = 7;
   localparam int FSSM_RSQ_FRAC_W = 4;

   // reset values
   localparam logic [31:0] FSSM_RESULT_RST = 32'h00000000;

   typedef enum logic [1:0] {
      FSSM_OP_RECIP = 2'b00,
      FSSM_OP_RSQRT = 2'b01,
      FSSM_OP_COPYSIGN = 2'b10,
      FSSM_OP_MIN = 2'b11
   } fssm_op_t;

   typedef struct packed {
      logic alu_carry_flag;
      logic alu_invalid_flag;
      logic alu_negative_flag;
      logic alu_sign_select_flag;
      logic alu_overflow_flag;
      logic alu_zero_flag;
   } fssm_arith_status_word_t;

   typedef struct packed {
      logic sticky_underflow_bit;
      logic sticky_fixed_overflow_bit;
      logic sticky_invalid_bit;
      logic sticky_overflow_bit;
   } fssm_sticky_status_word_t;

   typedef struct packed {
      logic [31:0] result;
      fssm_arith_status_word_t flags;
      fssm_sticky_status_word_t set;
   } fssm_out_t;

   localparam fssm_arith_status_word_t FSSM_ARITH_RST = '0;
   localparam fssm_sticky_status_word_t FSSM_STICKY_RST = '0;

   // 1/(1.f) scaled into [1,2): 2/(1+f) at the bucket centre, 8 fraction bits
   function automatic logic [7:0] fssm_rcp_entry(input int idx);
      int q;
      q = 131072 / (256 + 2 * idx + 1);
      return 8'(q - 256);
   endfunction

   // largest m/256 in [1,2) with (m/256)^2 * (1+f) <= lim, f = (2k+1)/256 for six-bit fraction index k
   function automatic logic [3:0] fssm_rsq_entry(input int idx);
      int lim;
      int den;
      int m;
      int best;
      lim = (idx >= 64) ? 67108864 : 33554432;
      den = 256 + 2 * (idx % 64) + 1;
      best = 256;
      for (m = 256; m < 512; m++) begin
         if (m * m * den <= lim) begin
            best = m;
         end
      end
      return 4'((best - 256) >> 4);
   endfunction

endpackage

`timescale 1ns/1ns
`default_nettype none

module fssm_seed_rom
   import fssm_pkg::*;
(
   // lookup indices
   input wire logic [FSSM_RCP_IDX_W-1:0] i_rcp_idx,
   input wire logic [FSSM_RSQ_IDX_W-1:0] i_rsq_idx,
   // seed fractions
   output logic [FSSM_RCP_FRAC_W-1:0] o_rcp_frac,
   output logic [FSSM_RSQ_FRAC_W-1:0] o_rsq_frac
);

   logic [FSSM_RCP_FRAC_W-1:0] rcp_tab [128];
   logic [FSSM_RSQ_FRAC_W-1:0] rsq_tab [128];

   for (genvar g = 0; g < 128; g++) begin : g_tab
      assign rcp_tab[g] = fssm_rcp_entry(g);
      assign rsq_tab[g] = fssm_rsq_entry(g);
   end

   assign o_rcp_frac = rcp_tab[i_rcp_idx];
   assign o_rsq_frac = rsq_tab[i_rsq_idx];

endmodule

`default_nettype wire

// ---- tb/fssm_alu_asserts.sv ----
// Purpose: port assertions for the seed/sign/min float slice
// Assumes: one clock, synchronous active-low reset
// Notes:   bound onto every instance of the slice
`timescale 1ns/1ns
`default_nettype none
module fssm_alu_asserts
   import fssm_pkg::*;
(
   // clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RSTN,
   // request
   input wire logic I_OP_VALID,
   input wire fssm_op_t I_OP_CODE,
   input wire logic [FSSM_W-1:0] I_OPND_X,
   input wire logic [FSSM_W-1:0] I_OPND_Y,
   input wire logic I_STICKY_CLR,
   // write-back
   input wire logic O_RES_VALID,
   input wire logic [FSSM_W-1:0] O_RESULT,
   input wire fssm_arith_status_word_t O_ARITH_STATUS,
   input wire fssm_sticky_status_word_t O_STICKY_STATUS
);
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RSTN);
   logic x_nan;
   logic y_nan;
   assign x_nan = (I_OPND_X[30:23] == 8'hFF) && (I_OPND_X[22:0] != 23'h0);
   assign y_nan = (I_OPND_Y[30:23] == 8'hFF) && (I_OPND_Y[22:0] != 23'h0);
   ////////////////////////////////////////////////////////////////
   a_valid_next: assert property (I_OP_VALID |=> O_RES_VALID)
      else $error("no result strobe after request");
   a_idle_hold: assert property (I_RSTN && !I_OP_VALID |=> !O_RES_VALID
      && $stable(O_RESULT) && $stable(O_ARITH_STATUS))
      else $error("outputs moved without request");
   a_carry_sel: assert property (O_RES_VALID |-> !O_ARITH_STATUS.alu_carry_flag
      && !O_ARITH_STATUS.alu_sign_select_flag)
      else $error("carry or select flag set");
   a_nan_ones: assert property (I_OP_VALID && x_nan |=> O_RESULT == FSSM_ALL_ONES
      && O_ARITH_STATUS.alu_invalid_flag)
      else $error("nan operand not all ones");
   a_inv_sticky: assert property (O_RES_VALID && O_ARITH_STATUS.alu_invalid_flag
      |-> O_STICKY_STATUS.sticky_invalid_bit)
      else $error("invalid not made sticky");
   a_no_ovf_two: assert property (I_OP_VALID && I_OP_CODE[1]
      |=> !O_ARITH_STATUS.alu_overflow_flag)
      else $error("overflow set by two-operand op");
   a_sign_copy: assert property (I_OP_VALID && I_OP_CODE == FSSM_OP_COPYSIGN
      && !x_nan && !y_nan |=> O_RESULT[31] == $past(I_OPND_Y[31]))
      else $error("copied sign wrong");
   a_fix_kept: assert property (!$rose(O_STICKY_STATUS.sticky_fixed_overflow_bit))
      else $error("fixed overflow sticky set");
   a_rcp_zero: assert property (I_OP_VALID && I_OP_CODE == FSSM_OP_RECIP
      && I_OPND_X[30:23] == 8'h00 |=> O_ARITH_STATUS.alu_overflow_flag
      && O_RESULT == {$past(I_OPND_X[31]), 31'h7F800000})
      else $error("zero reciprocal not infinity");
   a_rsq_neg: assert property (I_OP_VALID && I_OP_CODE == FSSM_OP_RSQRT
      |=> O_ARITH_STATUS.alu_negative_flag == $past(I_OPND_X[31] && I_OPND_X[30:23] == 8'h00))
      else $error("root negative flag wrong");
endmodule
bind fssm_alu fssm_alu_asserts u_fssm_alu_asserts (.I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN),
   .I_OP_VALID(I_OP_VALID), .I_OP_CODE(I_OP_CODE), .I_OPND_X(I_OPND_X),
   .I_OPND_Y(I_OPND_Y), .I_STICKY_CLR(I_STICKY_CLR), .O_RES_VALID(O_RES_VALID),
   .O_RESULT(O_RESULT), .O_ARITH_STATUS(O_ARITH_STATUS), .O_STICKY_STATUS(O_STICKY_STATUS));
`default_nettype wire

// ---- tb/fssm_rf_model.sv ----
// Purpose: register file entry that takes the slice's write-back
// Assumes: write on every result strobe
// Notes:   counts writes so lost or doubled strobes show up
`timescale 1ns/1ns
`default_nettype none
module fssm_rf_model
   import fssm_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // write-back port
   input wire logic i_wr,
   input wire logic [FSSM_W-1:0] i_data,
   // stored state
   output logic [FSSM_W-1:0] o_reg,
   output logic [7:0] o_wr_cnt
);
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_reg <= FSSM_RESULT_RST;
         o_wr_cnt <= 8'h00;
      end else if (i_wr) begin
         o_reg <= i_data;
         o_wr_cnt <= o_wr_cnt + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ---- tb/test_fssm_alu.sv ----
// Purpose: self-checking bench of the seed/sign/min float slice
// Assumes: 25 MHz clock, one-cycle answer
// Notes:   table rows clear sticky with each request, so sticky equals set bits
`timescale 1ns/1ns
`default_nettype none
module test_fssm_alu
   import fssm_pkg::*;
;
   typedef struct packed {
      logic [1:0] op;
      logic [31:0] x;
      logic [31:0] y;
      logic [31:0] r;
      logic [5:0] f;
      logic [3:0] s;
   } fssm_row_t;
   localparam int N_ROWS = 25;
   localparam fssm_row_t ROWS [N_ROWS] = '{
      '{2'h0,32'h3F800000,32'h0,32'h3F7F0000,6'h00,4'h0},
      '{2'h0,32'hC0000000,32'h0,32'hBEFF0000,6'h08,4'h0},
      '{2'h0,32'h00000000,32'h0,32'h7F800000,6'h02,4'h1},
      '{2'h0,32'h80000000,32'h0,32'hFF800000,6'h0A,4'h1},
      '{2'h0,32'h7E000000,32'h0,32'h00FF0000,6'h00,4'h0},
      '{2'h0,32'h7E800000,32'h0,32'h00000000,6'h01,4'h8},
      '{2'h0,32'hFE800000,32'h0,32'h80000000,6'h09,4'h8},
      '{2'h0,32'h7FC00000,32'h0,32'hFFFFFFFF,6'h10,4'h2},
      '{2'h1,32'h3F800000,32'h0,32'h3F780000,6'h00,4'h0},
      '{2'h1,32'h40800000,32'h0,32'h3EF80000,6'h00,4'h0},
      '{2'h1,32'h40000000,32'h0,32'h3EB00000,6'h00,4'h0},
      '{2'h1,32'h00000000,32'h0,32'h7F800000,6'h02,4'h1},
      '{2'h1,32'h80000000,32'h0,32'hFF800000,6'h0A,4'h1},
      '{2'h1,32'h7F800000,32'h0,32'h00000000,6'h01,4'h0},
      '{2'h1,32'hBF800000,32'h0,32'hFFFFFFFF,6'h10,4'h2},
      '{2'h1,32'hFF800000,32'h0,32'hFFFFFFFF,6'h10,4'h2},
      '{2'h2,32'h3F800000,32'h80000000,32'hBF800000,6'h08,4'h0},
      '{2'h2,32'hC0400000,32'h00000001,32'h40400000,6'h00,4'h0},
      '{2'h2,32'h80000005,32'h3F800000,32'h00000000,6'h01,4'h0},
      '{2'h2,32'h3F800000,32'h7FC00001,32'hFFFFFFFF,6'h10,4'h2},
      '{2'h3,32'h3F800000,32'h40000000,32'h3F800000,6'h00,4'h0},
      '{2'h3,32'h40000000,32'h3F800000,32'h3F800000,6'h00,4'h0},
      '{2'h3,32'hBF800000,32'h3F000000,32'hBF800000,6'h08,4'h0},
      '{2'h3,32'h7FC00000,32'h3F800000,32'hFFFFFFFF,6'h10,4'h2},
      '{2'h3,32'h00000003,32'h3F000000,32'h00000000,6'h01,4'h0}};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic vld = 1'b0;
   logic clr = 1'b0;
   fssm_op_t op = FSSM_OP_RECIP;
   logic [31:0] x = 32'h0;
   logic [31:0] y = 32'h0;
   logic res_vld;
   logic [31:0] res;
   fssm_arith_status_word_t ast;
   fssm_sticky_status_word_t sty;
   logic [31:0] rf_reg;
   logic [7:0] rf_cnt;
   int n_fail = 0;
   int n_checks = 0;
   always #20 clk = ~clk;
   fssm_alu u_fssm_alu (.I_REF_CLK(clk), .I_RSTN(rstn), .I_OP_VALID(vld), .I_OP_CODE(op),
      .I_OPND_X(x), .I_OPND_Y(y), .I_STICKY_CLR(clr), .O_RES_VALID(res_vld),
      .O_RESULT(res), .O_ARITH_STATUS(ast), .O_STICKY_STATUS(sty));
   fssm_rf_model u_fssm_rf_model (.i_clk(clk), .i_rstn(rstn), .i_wr(res_vld),
      .i_data(res), .o_reg(rf_reg), .o_wr_cnt(rf_cnt));
   ////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task drive(input logic [1:0] o, input logic [31:0] a, input logic [31:0] b, input logic c);
      vld <= 1'b1;
      op <= fssm_op_t'(o);
      x <= a;
      y <= b;
      clr <= c;
   endtask
   // one isolated request, then settle past the answering edge
   task one(input logic [1:0] o, input logic [31:0] a, input logic [31:0] b, input logic c);
      @(posedge clk);
      drive(o, a, b, c);
      @(posedge clk);
      vld <= 1'b0;
      clr <= 1'b0;
      #1;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      close_out;
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      #1;
      check(32'({res_vld, ast, sty}), 32'h0);
      // rows back to back, each answer checked one cycle later
      for (int i = 0; i <= N_ROWS; i++) begin
         @(posedge clk);
         if (i < N_ROWS) begin
            drive(ROWS[i].op, ROWS[i].x, ROWS[i].y, 1'b1);
         end else begin
            vld <= 1'b0;
            clr <= 1'b0;
         end
         #1;
         if (i > 0) begin
            check(32'(res_vld), 32'h1);
            check(res, ROWS[i-1].r);
            check(32'(ast), 32'(ROWS[i-1].f));
            check(32'(sty), 32'(ROWS[i-1].s));
         end
      end
      @(posedge clk);
      #1;
      check(32'(res_vld), 32'h0);
      check(res, ROWS[N_ROWS-1].r);
      check({rf_cnt, rf_reg[23:0]}, {8'h19, ROWS[N_ROWS-1].r[23:0]});
      one(2'h3, 32'h00000000, 32'h80000000, 1'b0);
      check(res, 32'h80000000);
      check(32'(ast.alu_zero_flag), 32'h1);
      // sticky bits accumulate until cleared
      one(2'h1, 32'h7F800000, 32'h0, 1'b1);
      check(32'({ast, sty}), 32'h10);
      one(2'h0, 32'h7E800000, 32'h0, 1'b0);
      check(32'(sty), 32'h8);
      one(2'h2, 32'h3F800000, 32'h7FC00001, 1'b0);
      check(32'(sty), 32'hA);
      one(2'h1, 32'h00000000, 32'h0, 1'b0);
      check(32'(sty), 32'hB);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      #1;
      check({res_vld, sty, res[26:0]}, {1'b0, 4'h0, 27'h7800000});
      // reset in mid-run, then a request at once
      @(posedge clk);
      rstn <= 1'b0;
      @(posedge clk);
      rstn <= 1'b1;
      #1;
      check(32'({res_vld, ast, sty}) | res, 32'h0);
      one(2'h0, 32'h3F800000, 32'h0, 1'b0);
      check(res, 32'h3F7F0000);
      close_out;
   end
endmodule
`default_nettype wire
